// ==== src/ocs_consts.svh ====
// constants for the otp calibration sequencer
`ifndef OCS_CONSTS_SVH
`define OCS_CONSTS_SVH
`define OCS_CHAIN_LEN      53
`define OCS_SEAL_POS       0
`define OCS_OP_CAL_MASK    8'hfc
`define OCS_OP_CAL         8'hf0
`define OCS_OP_DON_MASK    8'hfe
`define OCS_OP_DON         8'hae
`define OCS_OP_LOAD_MASK   8'hfe
`define OCS_OP_LOAD        8'hd8
`define OCS_BIT_CAL        0
`define OCS_BIT_OSE        1
`define OCS_BIT_DON        0
`define OCS_BIT_LOAD       0
`define OCS_REFRESH_MS     5
`define OCS_CLK_KHZ        50000
`define OCS_REFRESH_CYC    (`OCS_REFRESH_MS * `OCS_CLK_KHZ)
`endif

// ==== src/ocs_pkg.sv ====
// types for the otp calibration sequencer
package ocs_pkg;
  // one received interface byte
  typedef struct packed {
    logic       valid;
    logic       dc;
    logic [7:0] data;
  } ocs_cmd_t;
  // refresh sequencer states
  typedef enum logic [2:0] {
    OCS_IDLE    = 3'b001,
    OCS_PENDING = 3'b010,
    OCS_LOADING = 3'b100
  } ocs_state_t;
endpackage

// ==== src/ocs_otp_calibration_sequencer.sv ====
// otp calibration sequencer: mode control, shift chain, refresh and burn
`timescale 1ns/100ps
`include "ocs_consts.svh"
module ocs_otp_calibration_sequencer #(
  parameter int CHAIN_LEN   = `OCS_CHAIN_LEN,
  parameter int REFRESH_CYC = `OCS_REFRESH_CYC
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire ocs_pkg::ocs_cmd_t     cmd,
  input  wire logic                  power_down,
  input  wire logic                  otp_program_supply,
  input  wire logic [CHAIN_LEN-1:0]  otp_cells,
  output logic                       calibration_mode,
  output logic                       otp_switch_enable,
  output logic                       display_on,
  output logic [CHAIN_LEN-1:0]       calib_chain,
  output logic [CHAIN_LEN-1:0]       otp_burn,
  output logic                       cmd_normal_valid,
  output logic [7:0]                 cmd_normal_data,
  output logic                       cmd_normal_dc,
  output logic                       refresh_busy,
  output logic                       sealed
);
  import ocs_pkg::*;

  // elaboration check on parameters
  // the shift needs two positions at least and the reload one cycle at least
  if (CHAIN_LEN < 2 || REFRESH_CYC < 1) begin : g_bad_param
    $error("ocs: unsupported parameter value");
  end

  // opcode match helper, used for each command kind
  // fixed opcode bits must match; the masked low bits carry operands
  function automatic logic op_is(input logic [7:0] d, input logic [7:0] m,
                                 input logic [7:0] v);
    op_is = ((d & m) == v);
  endfunction

  // internal state and decode
  logic        pin_meta_r;    // supply pin sync stage one
  logic        pin_sync_r;    // supply pin sync stage two
  logic        pd_meta_r;     // power-down sync stage one
  logic        pd_sync_r;     // power-down sync stage two
  logic        is_cmd;        // command byte present
  logic        hit_cal;       // calibration command
  logic        hit_don;       // display on/off command
  logic        hit_load;      // load command
  logic        refresh_ok_r;  // refresh has completed since reset
  logic [$clog2(REFRESH_CYC+1)-1:0] cnt_r; // refresh wait counter
  ocs_state_t  state_r;       // refresh sequencer state

  // decode of incoming command bytes
  // only d/c-low bytes are commands, data bytes never hit an opcode
  assign is_cmd   = cmd.valid && !cmd.dc;
  assign hit_cal  = is_cmd && op_is(cmd.data, `OCS_OP_CAL_MASK, `OCS_OP_CAL);
  assign hit_don  = is_cmd && op_is(cmd.data, `OCS_OP_DON_MASK, `OCS_OP_DON);
  assign hit_load = is_cmd && op_is(cmd.data, `OCS_OP_LOAD_MASK, `OCS_OP_LOAD);

  // two-flop synchronisers for pin levels
  // power-down starts at its powered-down level so no reload begins early
  // only the second stage of each pair is read by the logic below
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      pd_meta_r  <= 1'b1;
      pd_sync_r  <= 1'b1;
    end else begin
      pin_meta_r <= otp_program_supply;
      pin_sync_r <= pin_meta_r;
      pd_meta_r  <= power_down;
      pd_sync_r  <= pd_meta_r;
    end
  end

  // display-on bit, ordinary command outside calibration
  // the bit is kept while powered down; only the reload waits for power-up
  always_ff @(posedge clock) begin
    if (reset) begin
      display_on <= 1'b0;
    end else if (hit_don && !calibration_mode) begin
      display_on <= cmd.data[`OCS_BIT_DON];
    end
  end

  // refresh sequencer: delayed while powered down, then waits
  // a second on/off while a reload is under way does not restart the count
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r      <= OCS_IDLE;
      cnt_r        <= '0;
      // the seal is unknown until the first reload completes
      refresh_ok_r <= 1'b0;
    end else begin
      case (state_r)
        OCS_IDLE: begin
          // each on/off write outside calibration requests a reload
          if (hit_don && !calibration_mode) begin
            state_r <= OCS_PENDING;
          end
        end
        OCS_PENDING: begin
          // reload waits until power-down is left
          if (!pd_sync_r) begin
            state_r <= OCS_LOADING;
            cnt_r   <= '0;
          end
        end
        OCS_LOADING: begin
          // the chain is overwritten from the cells on the last count
          if (cnt_r == ($bits(cnt_r))'(REFRESH_CYC - 1)) begin
            state_r      <= OCS_IDLE;
            refresh_ok_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: begin
          // unused codes fall back to idle
          state_r <= OCS_IDLE;
        end
      endcase
    end
  end

  // busy covers both the wait for power-up and the reload itself
  // the seal only means something once a reload has completed
  assign refresh_busy = (state_r != OCS_IDLE);
  assign sealed       = calib_chain[`OCS_SEAL_POS];

  // calibration mode and switch enable control
  // ose never stays up outside calibration: exit drops both bits together
  // re-entry from inside calibration may retune ose even when sealed
  always_ff @(posedge clock) begin
    if (reset) begin
      calibration_mode  <= 1'b0;
      otp_switch_enable <= 1'b0;
    end else if (hit_cal) begin
      if (!cmd.data[`OCS_BIT_CAL]) begin
        calibration_mode  <= 1'b0;
        otp_switch_enable <= 1'b0;
      end else if (calibration_mode || (refresh_ok_r && !refresh_busy && !sealed)) begin
        calibration_mode  <= 1'b1;
        otp_switch_enable <= cmd.data[`OCS_BIT_OSE];
      end
    end
  end

  // shift chain: refresh reload or serial load
  // a reload wins over a load in one cycle; loads are refused then anyway
  // chain drives device directly
  always_ff @(posedge clock) begin
    if (reset) begin
      calib_chain <= '0;
    end else if (state_r == OCS_LOADING &&
                 cnt_r == ($bits(cnt_r))'(REFRESH_CYC - 1)) begin
      calib_chain <= otp_cells;
    end else if (hit_load && calibration_mode) begin
      // one bit from d0 per load
      calib_chain <= {calib_chain[CHAIN_LEN-2:0], cmd.data[`OCS_BIT_LOAD]};
    end
  end
  // a short sequence leaves fields misplaced until the rest arrives

  // burn strobes for the otp cells
  // the supply pin passes its synchroniser first, so burning starts late
  // burn drops in the cycle after calibration or ose is left
  always_ff @(posedge clock) begin
    if (reset) begin
      otp_burn <= '0;
    end else begin
      otp_burn <= (calibration_mode && otp_switch_enable && pin_sync_r) ?
                  calib_chain : '0;
    end
  end

  // forwarding of ordinary bytes
  // data and dc are registered every cycle; only the valid pulse is qualified
  // calibration and load opcodes are swallowed even outside calibration
  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_normal_valid <= 1'b0;
      cmd_normal_data  <= 8'h00;
      cmd_normal_dc    <= 1'b0;
    end else begin
      cmd_normal_valid <= cmd.valid && !calibration_mode && !hit_cal && !hit_load;
      cmd_normal_data  <= cmd.data;
      cmd_normal_dc    <= cmd.dc;
    end
  end
endmodule // ocs_otp_calibration_sequencer

// ==== dv/ocs_sva.sv ====
// checker for the otp calibration sequencer
`timescale 1ns/100ps
`include "ocs_consts.svh"
module ocs_sva_chk #(parameter int CHAIN_LEN = 53) (
  input wire logic                 clock,
  input wire logic                 reset,
  input wire ocs_pkg::ocs_cmd_t    cmd,
  input wire logic                 calibration_mode,
  input wire logic                 otp_switch_enable,
  input wire logic [CHAIN_LEN-1:0] calib_chain,
  input wire logic [CHAIN_LEN-1:0] otp_burn,
  input wire logic                 cmd_normal_valid,
  input wire logic                 refresh_busy,
  input wire logic                 sealed
);
  import ocs_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // decoded command kinds
  wire logic op_s = cmd.valid && !cmd.dc;
  wire logic cal_s = op_s && ((cmd.data & `OCS_OP_CAL_MASK) == `OCS_OP_CAL);
  wire logic ld_s = op_s && ((cmd.data & `OCS_OP_LOAD_MASK) == `OCS_OP_LOAD);
  a_load_shift: assert property (ld_s && calibration_mode |=>
    calib_chain == {$past(calib_chain[CHAIN_LEN-2:0]), $past(cmd.data[0])}) else $error("shift");
  a_ose_in_cal: assert property (otp_switch_enable |-> calibration_mode) else $error("ose");
  a_burn_cal: assert property (!calibration_mode |=> otp_burn == '0) else $error("burn");
  a_burn_ose: assert property (!otp_switch_enable |=> otp_burn == '0) else $error("ose");
  a_seal_block: assert property (cal_s && cmd.data[0] && sealed && !calibration_mode
    |=> !calibration_mode) else $error("sealed");
  a_busy_block: assert property (cal_s && refresh_busy && !calibration_mode
    |=> !calibration_mode) else $error("busy");
  a_cal_exit: assert property (cal_s && !cmd.data[0] |=>
    !calibration_mode && !otp_switch_enable) else $error("exit");
  a_no_fwd: assert property (calibration_mode |=>
    !cmd_normal_valid) else $error("forward");
  c_load: cover property (ld_s && calibration_mode);
  c_burn: cover property (otp_burn != '0);
  c_seal: cover property (cal_s && sealed && !calibration_mode);
endmodule // ocs_sva_chk
bind ocs_otp_calibration_sequencer ocs_sva_chk #(.CHAIN_LEN(CHAIN_LEN)) i_sva (.clock, .reset,
  .cmd, .calibration_mode, .otp_switch_enable, .calib_chain, .otp_burn, .cmd_normal_valid,
  .refresh_busy, .sealed);

// ==== dv/ocs_host_model.sv ====
// host model sending command and data bytes
`timescale 1ns/100ps
module ocs_host_model (
  input wire logic          clock,
  output ocs_pkg::ocs_cmd_t cmd
);
  import ocs_pkg::*;
  initial cmd = '0;
  // one byte held across one edge, data scrambled when idle
  task automatic send(input logic dc, input logic [7:0] d);
    @(posedge clock) #1 cmd = '{1'b1, dc, d};
    @(posedge clock) #1 cmd = '{1'b0, dc, ~d};
  endtask
  // full shift-in sequence, first bit is the msb
  task automatic load(input logic [52:0] v);
    for (int i = 52; i >= 0; i--) send(1'b0, 8'hd8 | {7'h0, v[i]});
  endtask
endmodule // ocs_host_model

// ==== dv/ocs_otp_calibration_sequencer_tb.sv ====
// testbench for the otp calibration sequencer
`timescale 1ns/100ps
module ocs_otp_calibration_sequencer_tb;
  import ocs_pkg::*;
  logic clock, reset, power_down, otp_program_supply, calibration_mode, otp_switch_enable;
  logic display_on, cmd_normal_valid, cmd_normal_dc, refresh_busy, sealed;
  logic [52:0] otp_cells, calib_chain, otp_burn;
  logic [7:0]  cmd_normal_data, d;
  logic [8:0]  exp_q[$];   // noted forwarded bytes as {dc, data}
  logic [63:0] r;
  ocs_cmd_t    cmd;
  int n_errors = 0, check_count = 0, seed = 32'hc175;
  ocs_host_model i_host (.clock, .cmd);
  ocs_otp_calibration_sequencer #(.REFRESH_CYC(8)) i_dut (.clock, .reset, .cmd, .power_down,
    .otp_program_supply, .otp_cells, .calibration_mode, .otp_switch_enable, .display_on,
    .calib_chain, .otp_burn, .cmd_normal_valid, .cmd_normal_data, .cmd_normal_dc,
    .refresh_busy, .sealed);
  task automatic chk(input logic [52:0] seen, input logic [52:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: value mismatch", $time);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  // forwarded bytes against the oldest note
  always @(negedge clock) if (cmd_normal_valid === 1'b1) begin
    if (exp_q.size() == 0) chk(53'h1, 53'h0);
    else chk({44'h0, cmd_normal_dc, cmd_normal_data}, {44'h0, exp_q.pop_front()});
  end
  initial begin
    #100000 n_errors++;
    summarize();
  end
  initial begin
    reset = 1;
    power_down = 1;
    otp_program_supply = 0;
    r = {$random(seed), $random(seed)};
    otp_cells = r[52:0] & ~53'h1;
    repeat (6) @(posedge clock);
    #1 reset = 0;
    chk(calib_chain, 53'h0);
    chk({51'h0, calibration_mode, otp_switch_enable}, 53'h0);
    i_host.send(1'b0, 8'hf1);
    chk({52'h0, calibration_mode}, 53'h0);
    d = 8'($random(seed));
    exp_q.push_back({1'b1, d});
    i_host.send(1'b1, d);
    // leave power-down, wait for the refresh
    exp_q.push_back({1'b0, 8'haf});
    i_host.send(1'b0, 8'haf);
    power_down = 0;
    chk({52'h0, refresh_busy}, 53'h1);
    repeat (4) @(posedge clock) #1;
    for (int i = 0; i < 40 && refresh_busy !== 1'b0; i++) @(posedge clock) #1;
    chk(calib_chain, otp_cells);
    i_host.send(1'b0, 8'hf1);
    chk({51'h0, calibration_mode, otp_switch_enable}, 53'h2);
    i_host.send(1'b1, d);
    i_host.send(1'b0, 8'hae);
    chk({52'h0, display_on}, 53'h1);
    r = {$random(seed), $random(seed)};
    i_host.load(r[52:0] & ~53'h1);
    otp_program_supply = 1;
    chk(calib_chain, r[52:0] & ~53'h1);
    repeat (5) @(posedge clock);
    #1 chk(otp_burn, 53'h0);
    otp_program_supply = 0;
    i_host.send(1'b0, 8'hf0);
    chk({52'h0, calibration_mode}, 53'h0);
    // burn only the seal cell, which still reads zero
    i_host.send(1'b0, 8'hf3);
    i_host.load(53'h1);
    otp_program_supply = 1;
    repeat (5) @(posedge clock);
    #1 chk(otp_burn, 53'h1);
    otp_program_supply = 0;
    i_host.send(1'b0, 8'hf0);
    i_host.send(1'b0, 8'hf1);
    chk({51'h0, sealed, calibration_mode}, 53'h2);
    chk({45'h0, 8'(exp_q.size())}, 53'h0);
    summarize();
  end
endmodule // ocs_otp_calibration_sequencer_tb
